// ===== hdl/page_walk_pkg.sv
// Constants and carrier types for the two-level page translator
package page_walk_pkg;
	localparam int VA_W = 32;
	localparam int VPN_W = 20;
	localparam int VPN_PART_W = 10;
	localparam int OFF_W = 12;
	localparam int PPN_W = 22;
	localparam int PPN_LO_W = 10;
	localparam int SPA_W = 34;
	localparam int PTE_BYTES_LOG2 = 2;
	localparam int LEVELS = 2;
	// Entry field positions
	localparam int PTE_V = 0;
	localparam int PTE_R = 1;
	localparam int PTE_W = 2;
	localparam int PTE_X = 3;
	localparam int PTE_U = 4;
	localparam int PTE_G = 5;
	localparam int PTE_A = 6;
	localparam int PTE_D = 7;
	localparam int PTE_PPN_LSB = 10;
	// Register map (word aligned)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ROOT = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_LAST_PA = 8'h0C;
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_SUM = 1;
	localparam int CTRL_MXR = 2;
	localparam int CTRL_ADE = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [21:0] ROOT_RESET = 22'h00_0000;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	typedef enum logic [1:0] {
		ACC_FETCH,
		ACC_LOAD,
		ACC_STORE
	} access_e;

	typedef enum logic [1:0] {
		PRIV_USER,
		PRIV_SUPER,
		PRIV_MACHINE
	} priv_e;

	typedef struct packed {
		logic [VA_W-1:0] va;
		access_e acc;
		logic amo;
		priv_e priv;
	} xlate_req_s;

	typedef struct packed {
		logic valid;
		logic fault;
		access_e acc;
		logic global_map;
		logic [SPA_W-1:0] pa;
	} xlate_rsp_s;

	typedef struct packed {
		logic req;
		logic we;
		logic [SPA_W-1:0] addr;
		logic [31:0] wdata;
	} mem_req_s;
endpackage : page_walk_pkg

// ===== hdl/two_level_page_translation.sv
// Two-level page table walker with permission checks and A/D upkeep
// What this block does
// - Map 20-bit page number to 22-bit frame, offset passes through
// - Untranslated result is zero-extended to full physical width
// - Walk starts at root frame; 1024 four-byte entries per table
// - Entry with valid clear is invalid; other bits ignored
// - X/W/R zero means pointer, else leaf; write-no-read reserved
// - Fetch from non-executable leaf raises fetch fault
// - Load or load-reserved to unreadable page raises load fault
// - Store, store-conditional or atomic to unwritable page: store fault
// - Atomics never report load fault; unreadable gives store fault
// - User mode needs U set; supervisor data needs permit bit too
// - Supervisor fetch from U page always refused
// - Global bit on any walked entry makes mapping global
// - Software reserved field never affects translation
// - Fault option: fault when A clear, or store with D clear
// - Otherwise set A on access, D on store, in memory
// - Entry update is a plain store after all leaf checks; no lock held
// - D set only by real stores, in order
// - Update finishes before the access is released
// - Hardware never clears A or D
// - First-level leaf is 4 MiB page; misaligned one faults
// - Reservation set lies within one 4 KiB region
// - Invalid, write-no-read or reserved bits set raise fault
// - Two levels; pointer at last level raises fault
// - A/D updates go straight to memory
`timescale 1ns/1ps
module two_level_page_translation (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic req_valid_i,
	input wire page_walk_pkg::xlate_req_s req_i,
	output logic req_ready_o,
	output page_walk_pkg::xlate_rsp_s rsp_o,
	output page_walk_pkg::mem_req_s mem_o,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_rdata_i,
	output logic [page_walk_pkg::SPA_W-1:0] resv_base_o
);
	import page_walk_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_CHECK,
		ST_UPDATE,
		ST_DONE
	} walk_e;

	typedef struct packed {
		logic [3:0] ctrl;
		logic [PPN_W-1:0] root;
		logic [31:0] wb_dat;
		logic wb_ack;
		walk_e st;
		xlate_req_s req;
		logic req_ready;
		logic level;
		logic [PPN_W-1:0] table_ppn;
		logic [31:0] pte;
		logic global_seen;
		logic [1:0] fault_cnt;
		xlate_rsp_s rsp;
		mem_req_s mem;
		logic [SPA_W-1:0] resv_base;
	} state_s;

	state_s cur;
	state_s next_cur;

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// Address split and walk are written for this shape only
	if (SPA_W != PPN_W + OFF_W) begin : g_bad_pa_width
		$error("physical width must be frame plus offset");
	end
	if (VA_W != VPN_W + OFF_W) begin : g_bad_va_width
		$error("virtual width must be page number plus offset");
	end
	if (VPN_W != LEVELS * VPN_PART_W) begin : g_bad_vpn_split
		$error("page number must split evenly over the levels");
	end
	if (PTE_PPN_LSB + PPN_W != 32) begin : g_bad_entry_width
		$error("frame field must fill the top of the entry");
	end
	if (PTE_BYTES_LOG2 + VPN_PART_W != OFF_W) begin : g_bad_table_size
		$error("one table must fill exactly one page");
	end
	if (LEVELS != 2) begin : g_bad_levels
		$error("walker serves exactly two levels");
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [SPA_W-1:0] entry_addr(
		input logic [PPN_W-1:0] tbl,
		input logic [VPN_PART_W-1:0] idx
	);
		entry_addr = {tbl, idx, {PTE_BYTES_LOG2{1'b0}}};
	endfunction : entry_addr

	function automatic logic perm_ok(
		input logic [31:0] pte,
		input xlate_req_s r,
		input logic sum,
		input logic mxr
	);
		logic rd;
		logic ok;
		rd = pte[PTE_R] | (mxr & pte[PTE_X]);
		ok = 1'b0;
		// AMO only checks write; unreadable implies unwritable
		if (r.acc == ACC_FETCH) begin
			ok = pte[PTE_X];
		end else if (r.acc == ACC_STORE || r.amo) begin
			ok = pte[PTE_W];
		end else begin
			ok = rd;
		end
		if (r.priv == PRIV_USER) begin
			ok = ok & pte[PTE_U];
		end else if (pte[PTE_U]) begin
			if (r.acc == ACC_FETCH) begin
				ok = 1'b0;
			end else begin
				ok = ok & sum;
			end
		end
		perm_ok = ok;
	endfunction : perm_ok

	// Atomics report as stores so no load fault ever escapes
	function automatic access_e acc_tag(input xlate_req_s r);
		acc_tag = r.amo ? ACC_STORE : r.acc;
	endfunction : acc_tag

	function automatic logic [SPA_W-1:0] leaf_pa(
		input logic [PPN_W-1:0] ppn,
		input logic first_level,
		input logic [VA_W-1:0] va
	);
		// Megapage takes its low 10 frame bits from the address;
		// alignment was already enforced, so nothing is lost
		leaf_pa = {ppn[PPN_W-1:PPN_LO_W],
			first_level ? va[OFF_W +: VPN_PART_W] : ppn[PPN_LO_W-1:0],
			va[OFF_W-1:0]};
	endfunction : leaf_pa

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic wb_hit;
	logic is_store;
	logic is_leaf;
	logic bad_entry;
	logic [VPN_PART_W-1:0] vpn_idx;
	logic [PPN_W-1:0] leaf_ppn;

	always_comb begin
		next_cur = cur;
		wb_hit = wb_cyc_i & wb_stb_i & ~cur.wb_ack;
		is_store = (cur.req.acc == ACC_STORE) | cur.req.amo;
		vpn_idx = cur.level ? cur.req.va[VA_W-1 -: VPN_PART_W]
			: cur.req.va[OFF_W +: VPN_PART_W];
		// Reserved field bits 9:8 deliberately unused
		is_leaf = cur.pte[PTE_R] | cur.pte[PTE_W] | cur.pte[PTE_X];
		bad_entry = ~cur.pte[PTE_V]
			| (cur.pte[PTE_W] & ~cur.pte[PTE_R])
			| (~is_leaf & (cur.pte[PTE_D] | cur.pte[PTE_A]
			| cur.pte[PTE_U]));
		leaf_ppn = cur.pte[31:PTE_PPN_LSB];

		// Write lands with ack; master holds data through it
		next_cur.wb_ack = wb_hit;
		next_cur.rsp.valid = 1'b0;
		if (wb_hit) begin
			next_cur.wb_dat = UNMAPPED_READ;
			case (wb_adr_i)
				REG_CTRL: begin
					next_cur.wb_dat = {28'h000_0000, cur.ctrl};
					if (wb_we_i && wb_sel_i[0]) begin
						next_cur.ctrl = wb_dat_i[3:0];
					end
				end
				REG_ROOT: begin
					next_cur.wb_dat = {10'h000, cur.root};
					if (wb_we_i) begin
						if (wb_sel_i[0]) next_cur.root[7:0] = wb_dat_i[7:0];
						if (wb_sel_i[1]) next_cur.root[15:8] = wb_dat_i[15:8];
						if (wb_sel_i[2]) next_cur.root[21:16] = wb_dat_i[21:16];
					end
				end
				REG_STATUS: begin
					next_cur.wb_dat = {27'h000_0000, cur.fault_cnt,
						cur.st};
				end
				REG_LAST_PA: begin
					next_cur.wb_dat = cur.rsp.pa[SPA_W-1:2];
				end
				default: begin
					next_cur.wb_dat = UNMAPPED_READ;
				end
			endcase
		end

		case (cur.st)
			ST_IDLE: begin
				next_cur.req_ready = 1'b1;
				if (req_valid_i && cur.req_ready) begin
					next_cur.req = req_i;
					next_cur.req_ready = 1'b0;
					if (!cur.ctrl[CTRL_ENABLE] || req_i.priv == PRIV_MACHINE) begin
						// Untranslated: zero-extend
						next_cur.rsp.pa = {{(SPA_W-VA_W){1'b0}}, req_i.va};
						next_cur.rsp.fault = 1'b0;
						next_cur.rsp.global_map = 1'b0;
						next_cur.rsp.acc = acc_tag(req_i);
						next_cur.st = ST_DONE;
					end else begin
						next_cur.level = 1'b1;
						next_cur.table_ppn = cur.root;
						next_cur.global_seen = 1'b0;
						next_cur.st = ST_READ;
					end
				end
			end
			ST_READ: begin
				// Always fetch from memory, no cached copy
				next_cur.mem.req = 1'b1;
				next_cur.mem.we = 1'b0;
				next_cur.mem.addr = entry_addr(cur.table_ppn, vpn_idx);
				if (cur.mem.req && mem_ack_i) begin
					next_cur.mem.req = 1'b0;
					next_cur.pte = mem_rdata_i;
					next_cur.st = ST_CHECK;
				end
			end
			ST_CHECK: begin
				next_cur.rsp.acc = acc_tag(cur.req);
				next_cur.rsp.fault = 1'b1;
				next_cur.rsp.pa = {SPA_W{1'b0}};
				next_cur.rsp.global_map = cur.global_seen | cur.pte[PTE_G];
				next_cur.global_seen = cur.global_seen | cur.pte[PTE_G];
				next_cur.st = ST_DONE;
				if (bad_entry) begin
					next_cur.rsp.fault = 1'b1;
				end else if (!is_leaf) begin
					if (cur.level) begin
						next_cur.level = 1'b0;
						next_cur.table_ppn = leaf_ppn;
						next_cur.st = ST_READ;
					end else begin
						next_cur.rsp.fault = 1'b1;
					end
				end else if (!perm_ok(cur.pte, cur.req, cur.ctrl[CTRL_SUM],
						cur.ctrl[CTRL_MXR])) begin
					next_cur.rsp.fault = 1'b1;
				end else if (cur.level && leaf_ppn[PPN_LO_W-1:0] != '0) begin
					next_cur.rsp.fault = 1'b1;
				end else if (!cur.pte[PTE_A] || (is_store && !cur.pte[PTE_D])) begin
					if (cur.ctrl[CTRL_ADE]) begin
						next_cur.rsp.fault = 1'b1;
					end else begin
						// Only OR in bits; never clear A/D
						next_cur.pte[PTE_A] = 1'b1;
						next_cur.pte[PTE_D] = cur.pte[PTE_D] | is_store;
						next_cur.st = ST_UPDATE;
					end
				end else begin
					next_cur.rsp.fault = 1'b0;
				end
				if (!next_cur.rsp.fault && next_cur.st == ST_DONE) begin
					next_cur.rsp.pa = leaf_pa(leaf_ppn, cur.level, cur.req.va);
				end
			end
			ST_UPDATE: begin
				// Checks were done on the exact word being written back;
				// the write back is a plain store; no lock is held on the entry
				next_cur.mem.req = 1'b1;
				next_cur.mem.we = 1'b1;
				next_cur.mem.addr = entry_addr(cur.table_ppn, vpn_idx);
				next_cur.mem.wdata = cur.pte;
				if (cur.mem.req && mem_ack_i) begin
					// Access released only after write acknowledged
					next_cur.mem.req = 1'b0;
					next_cur.mem.we = 1'b0;
					next_cur.rsp.fault = 1'b0;
					next_cur.rsp.pa = leaf_pa(leaf_ppn, cur.level, cur.req.va);
					next_cur.st = ST_DONE;
				end
			end
			ST_DONE: begin
				next_cur.rsp.valid = 1'b1;
				// Two-bit counter wraps; a trend hint, not a total
				if (cur.rsp.fault) begin
					next_cur.fault_cnt = cur.fault_cnt + 2'd1;
				end
				if (!cur.rsp.fault && cur.req.acc == ACC_LOAD) begin
					next_cur.resv_base = {cur.rsp.pa[SPA_W-1:OFF_W],
						{OFF_W{1'b0}}};
				end
				next_cur.st = ST_IDLE;
			end
			default: begin
				next_cur.st = ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur <= '0;
			cur.ctrl <= CTRL_RESET;
			cur.root <= ROOT_RESET;
			cur.st <= ST_IDLE;
		end else begin
			cur <= next_cur;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign wb_dat_o = cur.wb_dat;
	assign wb_ack_o = cur.wb_ack;
	assign req_ready_o = cur.req_ready;
	assign rsp_o = cur.rsp;
	assign mem_o = cur.mem;
	assign resv_base_o = cur.resv_base;
endmodule : two_level_page_translation

// ===== bench/tlpt_chk.sv
// Port checker for the two-level page translator
`timescale 1ns/1ps
module tlpt_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic req_valid_i,
	input wire page_walk_pkg::xlate_req_s req_i,
	input wire logic req_ready_o,
	input wire page_walk_pkg::xlate_rsp_s rsp_o,
	input wire page_walk_pkg::mem_req_s mem_o,
	input wire logic mem_ack_i,
	input wire logic [33:0] resv_base_o
);
	import page_walk_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Request kept so the answer can be tied back to it
	xlate_req_s held;
	always_ff @(posedge clk_i) begin
		if (req_valid_i && req_ready_o) begin
			held <= req_i;
		end
	end
	sequence s_take;
		req_valid_i && req_ready_o;
	endsequence
	sequence s_done;
		rsp_o.valid;
	endsequence
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack not one cycle after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	a_rsp_pulse: assert property (s_done |=> !rsp_o.valid)
		else $error("response valid longer than one cycle");
	a_one_outstanding: assert property (s_take |=> !req_ready_o)
		else $error("second request accepted while busy");
	a_walk_bound: assert property (s_take |-> ##[2:80] s_done)
		else $error("no response to a request");
	a_offset_thru: assert property (s_done ##0 !rsp_o.fault |->
		rsp_o.pa[11:0] == held.va[11:0]) else $error("page offset altered");
	a_acc_tag: assert property (s_done |->
		rsp_o.acc == (held.amo ? ACC_STORE : held.acc))
		else $error("response tagged with wrong access type");
	a_amo_store: assert property (s_done ##0 held.amo |->
		rsp_o.acc == ACC_STORE) else $error("atomic not tagged as store");
	a_bypass_two: assert property (s_take ##0 req_i.priv == PRIV_MACHINE
		|-> ##2 s_done ##0 rsp_o.pa == {2'b00, held.va})
		else $error("bypass address not zero extended in two cycles");
	a_mem_held: assert property (mem_o.req && !mem_ack_i |=>
		mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we))
		else $error("table access changed before ack");
	a_accessed_set: assert property (mem_o.req && mem_o.we |->
		mem_o.wdata[PTE_A]) else $error("entry written with accessed clear");
	a_resv_align: assert property (resv_base_o[11:0] == 12'h000)
		else $error("reservation base not 4 KiB aligned");
endmodule : tlpt_chk
bind two_level_page_translation tlpt_chk u_chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .req_valid_i, .req_i, .req_ready_o, .rsp_o,
	.mem_o, .mem_ack_i, .resv_base_o);

// ===== bench/page_table_mem.sv
// Page-table memory model behind the walk port
`timescale 1ns/1ps
module page_table_mem (
	input wire logic clk_i,
	input wire page_walk_pkg::mem_req_s mem_i,
	input wire logic [1:0] lat_i,
	output logic ack_o,
	output logic [31:0] rdata_o
);
	import page_walk_pkg::*;
	logic [31:0] m [logic [33:0]];
	logic [1:0] wait_cnt = 2'h0;
	initial ack_o = 1'b0;
	initial rdata_o = 32'h0000_0000;
	// Idle data toggles so a stale word never passes for a reply
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (mem_i.req && !ack_o) begin
			if (wait_cnt == lat_i) begin
				wait_cnt <= 2'h0;
				ack_o <= 1'b1;
				if (mem_i.we) begin
					m[mem_i.addr] = mem_i.wdata;
				end else if (m.exists(mem_i.addr)) begin
					rdata_o <= m[mem_i.addr];
				end else begin
					rdata_o <= 32'h0000_0000;
				end
			end else begin
				wait_cnt <= wait_cnt + 2'h1;
			end
		end
	end
endmodule : page_table_mem

// ===== bench/testbench.sv
// Self-checking bench for the two-level page translator
`timescale 1ns/1ps
module testbench;
	import page_walk_pkg::*;
	typedef struct packed {
		logic [31:0] va;
		access_e acc;
		priv_e priv;
		logic [3:0] ctrl;
		logic [2:0] fl;
		logic [33:0] pa;
	} row_s;
	localparam access_e LD = ACC_LOAD;
	localparam access_e ST = ACC_STORE;
	localparam access_e FE = ACC_FETCH;
	localparam priv_e SU = PRIV_SUPER;
	// Flags: atomic, fault, global
	localparam row_s rows [22] = '{
		'{32'h0000_0ABC, LD, SU, 4'h1, 3'h0, 34'h0_1234_5ABC},
		'{32'h0000_1004, ST, SU, 4'h1, 3'h2, 34'h0},
		'{32'h0000_1008, LD, SU, 4'h1, 3'h0, 34'h0_0010_0008},
		'{32'h0000_1000, FE, SU, 4'h1, 3'h2, 34'h0},
		'{32'h0000_2010, LD, SU, 4'h1, 3'h2, 34'h0},
		'{32'h0000_2010, FE, SU, 4'h1, 3'h0, 34'h0_0020_0010},
		'{32'h0000_2010, ST, SU, 4'h1, 3'h6, 34'h0},
		'{32'h0000_2010, LD, SU, 4'h5, 3'h0, 34'h0_0020_0010},
		'{32'h0000_1004, LD, SU, 4'h1, 3'h6, 34'h0},
		'{32'h0000_3000, LD, SU, 4'h1, 3'h2, 34'h0},
		'{32'h0000_4000, LD, SU, 4'h1, 3'h2, 34'h0},
		'{32'h0000_5000, FE, SU, 4'h3, 3'h2, 34'h0},
		'{32'h0000_5000, LD, PRIV_USER, 4'h1, 3'h0, 34'h0_0030_0000},
		'{32'h0000_5000, LD, SU, 4'h1, 3'h2, 34'h0},
		'{32'h0000_5000, LD, SU, 4'h3, 3'h0, 34'h0_0030_0000},
		'{32'h0000_6000, ST, SU, 4'h1, 3'h0, 34'h0_0040_0000},
		'{32'h0000_7000, LD, SU, 4'h9, 3'h2, 34'h0},
		'{32'h0040_1234, ST, SU, 4'h1, 3'h1, 34'h0_0040_1234},
		'{32'h0080_0000, LD, SU, 4'h1, 3'h2, 34'h0},
		'{32'h00C0_0010, LD, SU, 4'h1, 3'h1, 34'h0_0000_5010},
		'{32'h0100_0000, LD, SU, 4'h1, 3'h2, 34'h0},
		'{32'hFFFF_F123, FE, PRIV_MACHINE, 4'h1, 3'h0, 34'h0_FFFF_F123}};
	// Table image: address, entry; pointers keep D, A, U clear
	localparam logic [65:0] img [15] = '{
		{34'h1000, 32'h0000_0801}, {34'h1004, 32'h0010_00EF},
		{34'h1008, 32'h0010_04CF}, {34'h100C, 32'h0000_0C21},
		{34'h1010, 32'h0000_1001}, {34'h2000, 32'h048D_17C7},
		{34'h2004, 32'h0004_0043}, {34'h2008, 32'h0008_0049},
		{34'h200C, 32'h0000_00FE}, {34'h2010, 32'h0000_0045},
		{34'h2014, 32'h000C_00DF}, {34'h2018, 32'h0010_0007},
		{34'h201C, 32'h0010_0407}, {34'h3000, 32'h0000_14C7},
		{34'h4000, 32'h0000_0801}};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic ack;
	logic req_valid = 1'b0;
	xlate_req_s req = '0;
	logic ready;
	xlate_rsp_s rsp;
	xlate_rsp_s s;
	mem_req_s mreq;
	logic mack;
	logic [31:0] mdat;
	logic [33:0] resv;
	logic [1:0] lat = 2'h0;
	logic [31:0] q;
	int n_fail = 0;
	int n_checks = 0;
	always #20 clk_i = ~clk_i;
	two_level_page_translation u_two_level_page_translation (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .req_valid_i(req_valid), .req_i(req),
		.req_ready_o(ready), .rsp_o(rsp), .mem_o(mreq), .mem_ack_i(mack),
		.mem_rdata_i(mdat), .resv_base_o(resv));
	page_table_mem u_page_table_mem (.clk_i(clk_i), .mem_i(mreq),
		.lat_i(lat), .ack_o(mack), .rdata_o(mdat));
	task automatic check(input string what, input logic [63:0] e,
		input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic wb_xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
	endtask : wb_xfer
	task automatic xlate(input xlate_req_s r);
		@(posedge clk_i);
		req_valid <= 1'b1;
		req <= r;
		do begin
			@(posedge clk_i);
		end while (ready !== 1'b1);
		req_valid <= 1'b0;
		do begin
			@(posedge clk_i);
		end while (rsp.valid !== 1'b1);
		s = rsp;
	endtask : xlate
	task automatic complete_run;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (8000) @(posedge clk_i);
		n_fail++;
		complete_run();
	end
	initial begin
		foreach (img[i]) u_page_table_mem.m[img[i][65:32]] = img[i][31:0];
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		wb_xfer(1'b1, REG_ROOT, 32'h0000_0001);
		wb_xfer(1'b0, REG_ROOT, 32'h0000_0000);
		check("root", 64'h1, 64'(q));
		foreach (rows[i]) begin
			wb_xfer(1'b1, REG_CTRL, {28'h000_0000, rows[i].ctrl});
			lat <= 2'(i % 3);
			xlate('{rows[i].va, rows[i].acc, rows[i].fl[2], rows[i].priv});
			check("rsp", 64'({rows[i].fl[1],
				rows[i].fl[2] ? ST : rows[i].acc,
				rows[i].fl[1] ? 35'h0 : {rows[i].fl[0], rows[i].pa}}),
				64'({s.fault, s.acc, s.fault ? 35'h0 : {s.global_map, s.pa}}));
			$display("test row %0d done", i);
		end
		check("upd", 64'h0010_00C7, 64'(u_page_table_mem.m[34'h2018]));
		check("ade", 64'h0010_0407, 64'(u_page_table_mem.m[34'h201C]));
		check("keep", 64'h048D_17C7, 64'(u_page_table_mem.m[34'h2000]));
		check("resv", 64'h5000, 64'(resv));
		wb_xfer(1'b0, REG_LAST_PA, 32'h0000_0000);
		check("last pa", 64'h3FFF_FC48, 64'(q));
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check("ready rst", 64'h1, 64'(ready));
		check("valid rst", 64'h0, 64'(rsp.valid));
		wb_xfer(1'b0, REG_CTRL, 32'h0000_0000);
		check("ctrl", 64'(CTRL_RESET), 64'(q));
		wb_xfer(1'b0, REG_ROOT, 32'h0000_0000);
		check("root rst", 64'(ROOT_RESET), 64'(q));
		wb_xfer(1'b0, 8'h40, 32'h0000_0000);
		check("unmapped", 64'(UNMAPPED_READ), 64'(q));
		$display("test reset and registers done");
		complete_run();
	end
endmodule : testbench
